// ==== design/expander_pkg.sv ====
// Constants, reset values and state type of the I/O expander target.
// Contract
// - Answer only to address 0111 followed by the three strap levels.
// - Address byte bit 0 high means read, low means write.
// - First byte after write address is the command; low bits pick register.
// - Selection persists across reads until a new write command byte.
// - Input register shows pin levels; writes to it are dropped.
// - Polarity bit set inverts that pin as seen in input register.
// - Output latch drives only output pins; reads return the latch.
// - Direction bit one makes pin input, zero enables the driver.
// - Reset: output latch and direction all ones, polarity all zeros.
// - Write: START, address, ack, command, ack, data bytes acked, STOP.
// - No index increment on writes; last data byte written is kept.
// - Read: write command, repeated START, read address, then data returned.
// - Multi-byte read keeps returning the same register, no byte limit.
// - Pins are captured at rising SCL edge of every acknowledge pulse.
// - STOP accepted anywhere in a read and ends the transfer cleanly.
// - Acknowledge low after matching address and after every received byte.
package expander_pkg;

  // ****************************************************************
  // Addressing and register selection
  // ****************************************************************
  localparam logic [3:0] ADDR_FIXED    = 4'h7;
  localparam logic [1:0] SEL_INPUT     = 2'h0;
  localparam logic [1:0] SEL_OUTPUT    = 2'h1;
  localparam logic [1:0] SEL_POLARITY  = 2'h2;
  localparam logic [1:0] SEL_DIR       = 2'h3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] OUTPUT_RST    = 8'hFF;
  localparam logic [7:0] POLARITY_RST  = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'hFF;
  localparam logic [7:0] POINTER_RST   = 8'h00;
  localparam logic [7:0] CAPTURE_RST   = 8'h00;
  localparam logic [7:0] SHIFT_RST     = 8'h00;

  // ****************************************************************
  // Bit counting
  // ****************************************************************
  localparam logic [3:0] BIT_CNT_RST   = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE   = 4'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Bus engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RD_MACK,
    ST_IGNORE
  } bus_state_t;

endpackage : expander_pkg

// ==== design/sync_2ff.sv ====
// Two-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module sync_2ff #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sync_2ff

// ==== design/line_events.sv ====
// Edge, START and STOP detection on synchronised SCL and SDA.
`timescale 1ns/1ps
module line_events (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Synchronised bus lines
  input  wire logic scl_s,
  input  wire logic sda_s,
  // Registered events, one cycle each, and the registered SDA level
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_ev,
  output logic      stop_ev,
  output logic      sda_lvl
);

  logic scl_d_r;
  logic sda_d_r;

  // Idle bus is high, so history resets high to avoid false events
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      start_ev <= 1'b0;
      stop_ev  <= 1'b0;
      sda_lvl  <= 1'b1;
    end else begin
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
      scl_rise <= scl_s & ~scl_d_r;
      scl_fall <= ~scl_s & scl_d_r;
      start_ev <= scl_s & scl_d_r & sda_d_r & ~sda_s;
      stop_ev  <= scl_s & scl_d_r & ~sda_d_r & sda_s;
      sda_lvl  <= sda_s;
    end
  end

endmodule : line_events

// ==== design/io_expander.sv ====
// Two-wire bus target with four 8-bit port registers.
`timescale 1ns/1ps
module io_expander (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Two-wire bus, open drain data
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address straps
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       addr_strap_bit2,
  // Port pins, bit n is port_pin_n
  input  wire logic [7:0] port_pin_in,
  output logic      [7:0] port_pin_out,
  output logic      [7:0] port_pin_oe
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  localparam int SYNC_W = 13;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic              scl_s;
  logic              sda_s;
  logic [7:0]        pins_s;
  logic [2:0]        strap_s;

  // Reset value high: idle bus and pulled-up pins look quiet
  // All pins are asynchronous to clk
  assign raw_in = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
                   port_pin_in, sda_in, scl_in};

  sync_2ff #(
    .WIDTH   (SYNC_W),
    .RST_VAL (13'h1FFF)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  // Split the synchronised vector
  assign scl_s   = sync_in[0];
  assign sda_s   = sync_in[1];
  assign pins_s  = sync_in[9:2];
  assign strap_s = sync_in[12:10];

  // ****************************************************************
  // Bus line events
  // ****************************************************************

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sda_lvl;

  line_events u_events (
    .clk      (clk),
    .nrst     (nrst),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start_ev (start_ev),
    .stop_ev  (stop_ev),
    .sda_lvl  (sda_lvl)
  );

  // ****************************************************************
  // State and registers
  // ****************************************************************

  expander_pkg::bus_state_t state_r;
  expander_pkg::bus_state_t state_nxt;

  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic       sda_oe_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] out_r;
  logic [7:0] pol_r;
  logic [7:0] dir_r;
  logic [7:0] cap_r;
  logic       wr_en;
  logic       cap_en;

  // ****************************************************************
  // Decode and selection
  // ****************************************************************

  logic [6:0] own_addr;
  logic       addr_match;
  logic       rw_read;
  logic       byte_done;
  logic [1:0] sel;
  logic [7:0] in_now;
  logic [7:0] rd_value;
  logic       wr_out;
  logic       wr_pol;
  logic       wr_dir;

  // Straps are live, so they must not move inside a frame
  // Own address from fixed pattern and live straps
  assign own_addr   = {expander_pkg::ADDR_FIXED, strap_s};
  assign addr_match = (shift_r[7:1] == own_addr);
  assign rw_read    = shift_r[0];
  assign byte_done  = (bit_cnt_r == expander_pkg::BITS_PER_BYTE);

  // Register selection from the stored pointer
  assign sel = ptr_r[1:0];

  // Pin level as software sees it, inverted where asked
  assign in_now = pins_s ^ pol_r;

  // Capture, not live pins, so a byte cannot tear while shifting
  // Read multiplexer; input returns the last acknowledge capture
  assign rd_value =
    (sel == expander_pkg::SEL_INPUT)    ? cap_r :
    (sel == expander_pkg::SEL_OUTPUT)   ? out_r :
    (sel == expander_pkg::SEL_POLARITY) ? pol_r :
                                          dir_r;

  // Write strobes; the input register has none on purpose
  // Each strobe lasts one clk at the byte end
  assign wr_out = wr_en & (sel == expander_pkg::SEL_OUTPUT);
  assign wr_pol = wr_en & (sel == expander_pkg::SEL_POLARITY);
  assign wr_dir = wr_en & (sel == expander_pkg::SEL_DIR);

  // ****************************************************************
  // Bus engine next state
  // ****************************************************************

  // Answers land about 4 clk after each SCL fall (2 sync flops,
  // 1 event flop, 1 state flop); SCL low must last at least that
  // STOP and START outrank all bit activity in every state
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    sda_oe_nxt  = sda_oe;
    ptr_nxt     = ptr_r;
    wr_en       = 1'b0;
    cap_en      = 1'b0;
    if (stop_ev) begin
      state_nxt  = expander_pkg::ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_ev) begin
      state_nxt   = expander_pkg::ST_ADDR;
      bit_cnt_nxt = expander_pkg::BIT_CNT_RST;
      sda_oe_nxt  = 1'b0;
    end else begin
      case (state_r)
        expander_pkg::ST_ADDR,
        expander_pkg::ST_CMD,
        expander_pkg::ST_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift_nxt   = {shift_r[6:0], sda_lvl};
            bit_cnt_nxt = bit_cnt_r + expander_pkg::BIT_CNT_ONE;
          end else if (scl_fall && byte_done) begin
            if (state_r == expander_pkg::ST_ADDR) begin
              if (addr_match) begin
                state_nxt  = expander_pkg::ST_ADDR_ACK;
                sda_oe_nxt = 1'b1;
              end else begin
                state_nxt = expander_pkg::ST_IGNORE;
              end
            end else if (state_r == expander_pkg::ST_CMD) begin
              ptr_nxt    = shift_r;
              state_nxt  = expander_pkg::ST_CMD_ACK;
              sda_oe_nxt = 1'b1;
            end else begin
              wr_en      = 1'b1;
              state_nxt  = expander_pkg::ST_WDATA_ACK;
              sda_oe_nxt = 1'b1;
            end
          end
        end
        expander_pkg::ST_ADDR_ACK: begin
          if (scl_rise) begin
            cap_en = 1'b1;
          end else if (scl_fall) begin
            if (rw_read) begin
              // Load the byte and drive its top bit at once
              state_nxt   = expander_pkg::ST_RDATA;
              shift_nxt   = rd_value;
              sda_oe_nxt  = ~rd_value[7];
              bit_cnt_nxt = expander_pkg::BIT_CNT_ONE;
            end else begin
              state_nxt   = expander_pkg::ST_CMD;
              sda_oe_nxt  = 1'b0;
              bit_cnt_nxt = expander_pkg::BIT_CNT_RST;
            end
          end
        end
        expander_pkg::ST_CMD_ACK,
        expander_pkg::ST_WDATA_ACK: begin
          if (scl_rise) begin
            cap_en = 1'b1;
          end else if (scl_fall) begin
            // Further bytes land in the same register
            state_nxt   = expander_pkg::ST_WDATA;
            sda_oe_nxt  = 1'b0;
            bit_cnt_nxt = expander_pkg::BIT_CNT_RST;
          end
        end
        expander_pkg::ST_RDATA: begin
          // Next bit changes only once SCL is seen low
          if (scl_fall) begin
            if (byte_done) begin
              state_nxt  = expander_pkg::ST_RD_MACK;
              sda_oe_nxt = 1'b0;
            end else begin
              sda_oe_nxt  = ~shift_r[6];
              shift_nxt   = {shift_r[6:0], 1'b0};
              bit_cnt_nxt = bit_cnt_r + expander_pkg::BIT_CNT_ONE;
            end
          end
        end
        expander_pkg::ST_RD_MACK: begin
          if (scl_rise) begin
            cap_en = 1'b1;
            // Master NACK ends our turn; line stays released
            if (sda_lvl) begin
              state_nxt = expander_pkg::ST_IGNORE;
            end
          end else if (scl_fall) begin
            // Same register again, no limit on the count
            state_nxt   = expander_pkg::ST_RDATA;
            shift_nxt   = rd_value;
            sda_oe_nxt  = ~rd_value[7];
            bit_cnt_nxt = expander_pkg::BIT_CNT_ONE;
          end
        end
        expander_pkg::ST_IGNORE: begin
          // Not ours or refused: wait for START or STOP
          sda_oe_nxt = 1'b0;
        end
        expander_pkg::ST_IDLE: begin
          // Bus free; clock pulses here carry nothing for us
          sda_oe_nxt = 1'b0;
        end
        default: begin
          state_nxt  = expander_pkg::ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Bus engine flops
  // ****************************************************************

  // Reset releases the data line at once
  // Engine state; SDA is only ever pulled low, never driven high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r   <= expander_pkg::ST_IDLE;
      bit_cnt_r <= expander_pkg::BIT_CNT_RST;
      shift_r   <= expander_pkg::SHIFT_RST;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      sda_oe    <= sda_oe_nxt;
      sda_out   <= 1'b0;
    end
  end

  // All eight bits kept; only the low two select a register
  // Command pointer, changed only by a command byte of a write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ptr_r <= expander_pkg::POINTER_RST;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // ****************************************************************
  // Port registers
  // ****************************************************************

  // Output latch and polarity; each data byte overwrites the last
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_r <= expander_pkg::OUTPUT_RST;
      pol_r <= expander_pkg::POLARITY_RST;
    end else begin
      if (wr_out) begin
        out_r <= shift_r;
      end
      if (wr_pol) begin
        pol_r <= shift_r;
      end
    end
  end

  // One extra flop traded for a gate between flop and pin
  // Direction kept with a pre-inverted enable so the pin comes off a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_r       <= expander_pkg::DIR_RST;
      port_pin_oe <= ~expander_pkg::DIR_RST;
    end else if (wr_dir) begin
      dir_r       <= shift_r;
      port_pin_oe <= ~shift_r;
    end
  end

  // Latch drives the pad; the enable masks it on inputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      port_pin_out <= expander_pkg::OUTPUT_RST;
    end else begin
      port_pin_out <= out_r;
    end
  end

  // Polarity is applied here, at capture, not at read time
  // Snapshot of pins at each acknowledge rise, read back later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_r <= expander_pkg::CAPTURE_RST;
    end else if (cap_en) begin
      cap_r <= in_now;
    end
  end

endmodule : io_expander

// ==== test/io_expander_chk.sv ====
// Concurrent checks on the expander bus target and its port pins.
`timescale 1ns/1ps
module io_expander_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Two-wire bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Address straps
  input wire logic       addr_strap_bit0,
  input wire logic       addr_strap_bit1,
  input wire logic       addr_strap_bit2,
  // Port pins
  input wire logic [7:0] port_pin_in,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe
);
  // **********
  // Bus decode
  // **********
  logic       scl_r, sda_r, first_r, rd_r, mis_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  // Raw lines sampled once more, so START and STOP show as pairs
  wire start_w = scl_in && scl_r && sda_r && !sda_in;
  wire stop_w  = scl_in && scl_r && !sda_r && sda_in;
  wire rise_w  = scl_in && !scl_r;
  wire byte_w  = rise_w && (cnt_r == 4'h8);
  wire match_w = (sh_r[7:1] == {4'h7, addr_strap_bit2, addr_strap_bit1,
                                addr_strap_bit0});
  // Bit count per byte; byte_w marks the acknowledge rise
  always_ff @(posedge clk) begin
    scl_r <= scl_in;
    sda_r <= sda_in;
    if (!nrst || start_w || stop_w) begin
      cnt_r   <= 4'h0;
      first_r <= 1'b1;
      mis_r   <= 1'b0;
      rd_r    <= 1'b0;
      sh_r    <= 8'h00;
    end else if (rise_w) begin
      cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      sh_r  <= {sh_r[6:0], sda_in};
      if (byte_w) begin
        first_r <= 1'b0;
      end
      if (byte_w && first_r) begin
        rd_r  <= sh_r[0];
        mis_r <= !match_w;
      end
    end
  end
  // **********
  // Assertions
  // **********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  AST_RESET_PORTS: assert property (disable iff (1'b0)
    $rose(nrst) |-> port_pin_oe == 8'h00 && port_pin_out == 8'hFF)
    else $error("port pins not at reset state");
  AST_ADDR_ACK: assert property (byte_w && first_r && match_w
    |-> ##2 sda_oe) else $error("own address not acknowledged");
  AST_ADDR_NACK: assert property (mis_r |-> !sda_oe)
    else $error("foreign transfer driven");
  AST_DATA_ACK: assert property (byte_w && !first_r && !rd_r
    && !mis_r |-> ##2 sda_oe) else $error("written byte not acknowledged");
  AST_RD_RELEASE: assert property (byte_w && !first_r && rd_r
    |-> ##2 !sda_oe) else $error("line held in master ack bit");
  AST_STOP_IDLE: assert property (stop_w |-> !sda_oe [*8])
    else $error("line driven after stop");
  AST_PORT_WRITE: assert property (!$stable(port_pin_out)
    || !$stable(port_pin_oe) |-> !first_r && !rd_r
    && (cnt_r == 4'h8 || cnt_r == 4'h0))
    else $error("port pins changed outside a data byte end");
  COV_READ: cover property (byte_w && !first_r && rd_r);
  COV_WRITE: cover property (byte_w && !first_r && !rd_r && !mis_r);
  COV_FOREIGN: cover property ($rose(mis_r));
endmodule : io_expander_chk

bind io_expander io_expander_chk io_expander_chk_i (
  .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(addr_strap_bit0),
  .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit2(addr_strap_bit2),
  .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_pin_oe(port_pin_oe)
);

// ==== test/bus_master.sv ====
// Behavioural two-wire bus master that reaches the expander registers.
`timescale 1ns/1ps
module bus_master (
  // Clock
  input  wire logic clk,
  // Resolved data wire
  input  wire logic sda_w,
  // Driven lines, data released when high
  output logic      scl,
  output logic      sda_o
);
  // ***************************
  // Phases: 4 clk low, 4 high
  // ***************************
  initial begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end
  // Set both lines, then hold them for n cycles
  task automatic ph(input logic c, input logic d, input int n);
    scl   <= c;
    sda_o <= d;
    repeat (n) @(posedge clk);
  endtask : ph
  // Data moves mid-low; sampled late in high to cover sync latency
  task automatic bx(input logic b, output logic r);
    ph(1'b0, sda_o, 2);
    ph(1'b0, b, 2);
    ph(1'b1, b, 3);
    r = sda_w;
    ph(1'b1, b, 1);
  endtask : bx
  // Start; rep first lowers SCL for a repeated start in a frame,
  // so the clock stands still on an idle bus
  task automatic st(input logic rep);
    if (rep) begin
      ph(1'b0, sda_o, 2);
      ph(1'b0, 1'b1, 2);
    end
    ph(1'b1, 1'b1, 4);
    ph(1'b1, 1'b0, 4);
  endtask : st
  // Stop; clock then stands high until the next frame
  task automatic sp;
    ph(1'b0, sda_o, 2);
    ph(1'b0, 1'b0, 2);
    ph(1'b1, 1'b0, 4);
    ph(1'b1, 1'b1, 8);
  endtask : sp
  // Byte out MSB first, ok cleared on a missing acknowledge
  task automatic tx(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bx(b[i], r);
    end
    bx(1'b1, r);
    ok = ok & ~r;
  endtask : tx
  // Byte in, then ack or, on the last byte, no ack
  task automatic rx(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bx(1'b1, r);
      b[i] = r;
    end
    bx(last, r);
  endtask : rx
  // Register write, one or two data bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [7:0] d0, input logic [7:0] d1,
                    input logic two, output logic ok);
    ok = 1'b1;
    st(1'b0);
    tx({a, 1'b0}, ok);
    tx(c, ok);
    if (two) begin
      tx(d0, ok);
    end
    tx(d1, ok);
    sp;
  endtask : wr
  // Two-byte read; cut stops after three bits of the first byte
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    input logic uc, input logic cut,
                    output logic [7:0] b0, output logic [7:0] b1,
                    output logic ok);
    logic r;
    ok = 1'b1;
    if (uc) begin
      st(1'b0);
      tx({a, 1'b0}, ok);
      tx(c, ok);
    end
    st(uc);
    tx({a, 1'b1}, ok);
    if (cut) begin
      repeat (3) bx(1'b1, r);
    end else begin
      rx(1'b0, b0);
      rx(1'b1, b1);
    end
    sp;
  endtask : rd
endmodule : bus_master

// ==== test/io_expander_tb.sv ====
// Self-checking bench for the I/O expander bus target.
`timescale 1ns/1ps
module io_expander_tb;
  // *******
  // Signals
  // *******
  logic       clk, nrst, scl, sda_m, sda_oe, sda_out, ok;
  logic [2:0] strap;
  logic [6:0] addr;
  logic [6:0] bad [2] = '{7'h38, 7'h7D};
  logic [7:0] ext, pin_out, pin_oe, pin_w, b0, b1;
  int         n_errors, cmp_count;
  // Open drain data with pull-up; port pins read ext wherever not driven
  wire        sda_w = sda_m & ~(sda_oe & ~sda_out);
  assign pin_w = (pin_oe & pin_out) | (~pin_oe & ext);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  io_expander io_expander_i (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .port_pin_in(pin_w), .port_pin_out(pin_out), .port_pin_oe(pin_oe)
  );
  bus_master bus_master_i (
    .clk(clk), .sda_w(sda_w), .scl(scl), .sda_o(sda_m)
  );
  // *****
  // Tasks
  // *****
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // Read two bytes; both must equal the expected value
  task automatic rd_chk(input logic [7:0] c, input logic uc,
                        input logic [7:0] exp);
    bus_master_i.rd(addr, c, uc, 1'b0, b0, b1, ok);
    check({7'h00, ok}, 8'h01);
    check(b0, exp);
    check(b1, exp);
  endtask : rd_chk
  task automatic wr_chk(input logic [7:0] c, input logic [7:0] d0,
                        input logic [7:0] d1, input logic two,
                        input logic e);
    bus_master_i.wr(addr, c, d0, d1, two, ok);
    check({7'h00, ok}, {7'h00, e});
  endtask : wr_chk
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done;
  end
  // *************
  // Main sequence
  // *************
  initial begin
    nrst      = 1'b0;
    strap     = 3'h5;
    addr      = 7'h3D;
    ext       = 8'h96;
    n_errors  = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    check(pin_oe, 8'h00);
    check(pin_out, 8'hFF);
    rd_chk(8'h01, 1'b1, 8'hFF);
    rd_chk(8'h02, 1'b1, 8'h00);
    rd_chk(8'h03, 1'b1, 8'hFF);
    $display("test reset_values done");
    wr_chk(8'h01, 8'hA5, 8'h3C, 1'b1, 1'b1);
    rd_chk(8'h01, 1'b1, 8'h3C);
    wr_chk(8'h03, 8'h00, 8'h0F, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    check(pin_oe, 8'hF0);
    check(pin_out, 8'h3C);
    rd_chk(8'h03, 1'b1, 8'h0F);
    rd_chk(8'h07, 1'b1, 8'h0F);
    $display("test write_regs done");
    // Pins read 30 from the latch plus the low nibble, which is then inverted
    wr_chk(8'h02, 8'h00, 8'h0F, 1'b0, 1'b1);
    rd_chk(8'h00, 1'b1, 8'h39);
    ext <= 8'h5A;
    rd_chk(8'h00, 1'b0, 8'h35);
    bus_master_i.rd(addr, 8'h00, 1'b0, 1'b1, b0, b1, ok);
    check({7'h00, ok}, 8'h01);
    rd_chk(8'h00, 1'b0, 8'h35);
    wr_chk(8'h00, 8'h00, 8'hFF, 1'b0, 1'b1);
    rd_chk(8'h00, 1'b0, 8'h35);
    rd_chk(8'h01, 1'b1, 8'h3C);
    $display("test input_reads done");
    foreach (bad[i]) begin
      addr = bad[i];
      wr_chk(8'h01, 8'h00, 8'h00, 1'b0, 1'b0);
    end
    addr = 7'h3D;
    rd_chk(8'h01, 1'b1, 8'h3C);
    strap <= 3'h0;
    addr = 7'h38;
    rd_chk(8'h01, 1'b1, 8'h3C);
    $display("test addressing done");
    test_done;
  end
endmodule : io_expander_tb
